// ===== core/alarm_month_weekday.sv
// Month and weekday alarm comparator with an AXI4-Lite register slave.
`timescale 1ns/1ps
// Functional notes
// - The alarm can only be raised while the stored alarm month equals the current calendar month.
// - The alarm month is a five-bit BCD code from 01h to 12h, and the code 00h never matches.
// - Bit 7 of the weekday alarm register decides whether the weekday compare takes part.
// - Bits 2 to 0 hold the alarm weekday, which matches when it equals the current weekday counter.
// - The weekday code is a zero-based index, stored and compared exactly as written.
module alarm_month_weekday (
    input wire logic CLK, // 200 MHz clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [4:0] AWADDR, // write address
    input wire logic AWVALID, // write address valid
    output logic AWREADY, // write address ready
    input wire logic [31:0] WDATA, // write data
    input wire logic [3:0] WSTRB, // write byte enables
    input wire logic WVALID, // write data valid
    output logic WREADY, // write data ready
    output logic [1:0] BRESP, // write response
    output logic BVALID, // write response valid
    input wire logic BREADY, // write response ready
    input wire logic [4:0] ARADDR, // read address
    input wire logic ARVALID, // read address valid
    output logic ARREADY, // read address ready
    output logic [31:0] RDATA, // read data
    output logic [1:0] RRESP, // read response
    output logic RVALID, // read data valid
    input wire logic RREADY, // read data ready
    input wire logic [4:0] CUR_MONTH, // current month from calendar
    input wire logic [2:0] CUR_WEEKDAY, // current weekday from calendar
    input wire logic OTHER_MATCH, // all other enabled fields match
    output logic ALARM_MATCH, // combined alarm match, registered
    output logic IRQ // level interrupt
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [alarm_match_pkg::MONTH_W-1:0] month_alarm, next_month_alarm;
    alarm_match_pkg::weekday_alarm_type wd_alarm, next_wd_alarm;
    logic [alarm_match_pkg::EVENT_W-1:0] status, next_status;
    logic [alarm_match_pkg::EVENT_W-1:0] mask, next_mask;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    alarm_match_pkg::write_hold_type hold, next_hold;
    logic bvalid_q, next_bvalid;
    logic [1:0] bresp_q, next_bresp;
    logic rvalid_q, next_rvalid;
    logic [1:0] rresp_q, next_rresp;
    logic [31:0] rdata_q, next_rdata;
    logic alarm_q, next_alarm;

    logic month_hit, weekday_hit, match;
    logic aw_take, w_take, ar_take, do_write;
    logic [alarm_match_pkg::EVENT_W-1:0] events, clear;
    logic bad_month;
    logic [alarm_match_pkg::MONTH_W-1:0] wr_month;

    assign AWREADY = !aw_held && !bvalid_q;
    assign WREADY = !w_held && !bvalid_q;
    assign ARREADY = !rvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RRESP = rresp_q;
    assign RDATA = rdata_q;
    assign ALARM_MATCH = alarm_q;
    // Status and mask are both flops, so the level carries no glitch.
    assign IRQ = |(status & mask);

    assign aw_take = AWVALID && AWREADY;
    assign w_take = WVALID && WREADY;
    assign ar_take = ARVALID && ARREADY;
    assign do_write = aw_held && w_held;
    assign wr_month = hold.data[alarm_match_pkg::MONTH_W-1:0];

    // ------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------
    // month compare
    assign month_hit = (month_alarm == CUR_MONTH) && (month_alarm != alarm_match_pkg::MONTH_INVALID);
    assign weekday_hit = (wd_alarm.alarm_weekday_value == CUR_WEEKDAY);
    assign match = month_hit && OTHER_MATCH && (!wd_alarm.weekday_alarm_enable || weekday_hit);

    // A month code outside 01h..12h is still stored so software can read it back, but it is flagged.
    assign bad_month = (wr_month == alarm_match_pkg::MONTH_INVALID) || (wr_month > alarm_match_pkg::MONTH_LAST)
        || (wr_month[3:0] > alarm_match_pkg::BCD_UNITS_MAX);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_month_alarm = month_alarm;
        next_wd_alarm = wd_alarm;
        next_mask = mask;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_hold = hold;
        next_bvalid = bvalid_q;
        next_bresp = bresp_q;
        next_rvalid = rvalid_q;
        next_rresp = rresp_q;
        next_rdata = rdata_q;
        next_alarm = match;
        events = '0;
        clear = '0;
        events[alarm_match_pkg::EV_ALARM] = match && !alarm_q;
        if (aw_take) begin
            next_aw_held = 1'b1;
            next_hold.addr = AWADDR;
        end
        if (w_take) begin
            next_w_held = 1'b1;
            next_hold.data = WDATA;
            next_hold.lane0 = WSTRB[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = alarm_match_pkg::RESP_OKAY;
            case (hold.addr)
                alarm_match_pkg::OFF_MONTH: begin
                    if (hold.lane0) begin
                        next_month_alarm = wr_month;
                        events[alarm_match_pkg::EV_BAD_MONTH] = bad_month;
                    end
                end
                alarm_match_pkg::OFF_WEEKDAY: begin
                    if (hold.lane0) begin
                        next_wd_alarm.weekday_alarm_enable = hold.data[alarm_match_pkg::WD_EN_BIT];
                        next_wd_alarm.alarm_weekday_value = hold.data[alarm_match_pkg::DAY_W-1:0];
                    end
                end
                alarm_match_pkg::OFF_MASK: begin
                    if (hold.lane0) begin
                        next_mask = hold.data[alarm_match_pkg::EVENT_W-1:0];
                    end
                end
                alarm_match_pkg::OFF_STATUS, alarm_match_pkg::OFF_CURRENT: begin
                    next_bresp = alarm_match_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = alarm_match_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bvalid_q && BREADY) begin
            next_bvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp = alarm_match_pkg::RESP_OKAY;
            next_rdata = 32'h00000000;
            case (ARADDR)
                alarm_match_pkg::OFF_MONTH: begin
                    next_rdata[alarm_match_pkg::MONTH_W-1:0] = month_alarm;
                end
                alarm_match_pkg::OFF_WEEKDAY: begin
                    next_rdata[alarm_match_pkg::WD_EN_BIT] = wd_alarm.weekday_alarm_enable;
                    next_rdata[alarm_match_pkg::DAY_W-1:0] = wd_alarm.alarm_weekday_value;
                end
                alarm_match_pkg::OFF_STATUS: begin
                    next_rdata[alarm_match_pkg::EVENT_W-1:0] = status;
                    clear = status;
                end
                alarm_match_pkg::OFF_MASK: begin
                    next_rdata[alarm_match_pkg::EVENT_W-1:0] = mask;
                end
                alarm_match_pkg::OFF_CURRENT: begin
                    next_rdata[alarm_match_pkg::DAY_W-1:0] = CUR_WEEKDAY;
                    next_rdata[alarm_match_pkg::CUR_MONTH_LSB +: alarm_match_pkg::MONTH_W] = CUR_MONTH;
                    next_rdata[alarm_match_pkg::CUR_MONTH_LSB - 1] = alarm_q;
                end
                default: begin
                    next_rresp = alarm_match_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && RREADY) begin
            next_rvalid = 1'b0;
        end
        // A new event in the clearing read's cycle survives the clear.
        next_status = (status & ~clear) | events;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            month_alarm <= alarm_match_pkg::MONTH_RESET;
            wd_alarm.weekday_alarm_enable <= alarm_match_pkg::WD_EN_RESET;
            wd_alarm.alarm_weekday_value <= alarm_match_pkg::DAY_RESET;
            status <= alarm_match_pkg::EVENT_RESET;
            mask <= alarm_match_pkg::EVENT_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            hold <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= alarm_match_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= alarm_match_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
            alarm_q <= 1'b0;
        end else begin
            month_alarm <= next_month_alarm;
            wd_alarm <= next_wd_alarm;
            status <= next_status;
            mask <= next_mask;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            hold <= next_hold;
            bvalid_q <= next_bvalid;
            bresp_q <= next_bresp;
            rvalid_q <= next_rvalid;
            rresp_q <= next_rresp;
            rdata_q <= next_rdata;
            alarm_q <= next_alarm;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_weekday_write;
        do_write && hold.lane0 && (hold.addr == alarm_match_pkg::OFF_WEEKDAY);
    endsequence

    sequence s_weekday_read;
        ar_take && (ARADDR == alarm_match_pkg::OFF_WEEKDAY);
    endsequence

    property p_month_match;
        @(posedge CLK) disable iff (RST) $rose(ALARM_MATCH) |-> $past(month_alarm) == $past(CUR_MONTH);
    endproperty
    a_month_match: assert property (p_month_match) else $error("alarm rose without a month match");

    property p_month_invalid;
        @(posedge CLK) disable iff (RST) (month_alarm == alarm_match_pkg::MONTH_INVALID) |=> !ALARM_MATCH;
    endproperty
    a_month_invalid: assert property (p_month_invalid) else $error("invalid month code matched");

    property p_weekday_off;
        @(posedge CLK) disable iff (RST)
            (month_hit && OTHER_MATCH && !wd_alarm.weekday_alarm_enable) |=> ALARM_MATCH;
    endproperty
    a_weekday_off: assert property (p_weekday_off) else $error("disabled weekday blocked the alarm");

    property p_weekday_hit;
        @(posedge CLK) disable iff (RST)
            (ALARM_MATCH && $past(wd_alarm.weekday_alarm_enable)) |-> $past(weekday_hit);
    endproperty
    a_weekday_hit: assert property (p_weekday_hit) else $error("alarm with enabled weekday mismatch");

    property p_weekday_store;
        @(posedge CLK) disable iff (RST)
            s_weekday_write |=> wd_alarm.alarm_weekday_value == $past(hold.data[2:0]);
    endproperty
    a_weekday_store: assert property (p_weekday_store) else $error("weekday code not stored as written");

    property p_all_fields;
        @(posedge CLK) disable iff (RST) ALARM_MATCH |-> $past(OTHER_MATCH) && $past(month_hit);
    endproperty
    a_all_fields: assert property (p_all_fields) else $error("alarm without all fields matching");

    property p_unused_zero;
        @(posedge CLK) disable iff (RST) s_weekday_read |=> RVALID && (RDATA[6:3] == 4'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("weekday unused bits not zero");
endmodule

// ===== dv/axil_host_model.sv
// Behavioural AXI4-Lite host issuing one register access at a time.
`timescale 1ns/1ps
module axil_host_model (
    input wire logic clk, // bus clock
    output logic [4:0] awaddr, // write address
    output logic awvalid, // write address valid
    input wire logic awready, // write address ready
    output logic [31:0] wdata, // write data
    output logic [3:0] wstrb, // write strobes
    output logic wvalid, // write data valid
    input wire logic wready, // write data ready
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // write response valid
    output logic bready, // write response ready
    output logic [4:0] araddr, // read address
    output logic arvalid, // read address valid
    input wire logic arready, // read address ready
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp, // read response
    input wire logic rvalid, // read valid
    output logic rready // read ready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
    end
    // ----
    // Transfers
    // ----
    // A response of 3 means the wait ran out; the design never answers that.
    task automatic write_reg(input logic [4:0] addr, input logic [31:0] data, output logic [1:0] resp);
        resp = 2'h3;
        @(posedge clk);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic read_reg(input logic [4:0] addr, output logic [31:0] data, output logic [1:0] resp);
        resp = 2'h3;
        data = '0;
        @(posedge clk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ===== dv/test_alarm_month_weekday.sv
// Self-checking bench for the month and weekday alarm comparator.
`timescale 1ns/1ps
module test_alarm_month_weekday;
    typedef struct packed {
        logic [4:0] month; logic [7:0] wd_reg; logic [4:0] cur_month;
        logic [2:0] cur_wd; logic other; logic match;
    } row_type;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [4:0] awaddr, araddr, cur_month;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, okay, slverr;
    logic [2:0] cur_weekday;
    logic other_match, alarm_match, irq;
    int n_errors = 0;
    int checks_done = 0;
    row_type rows [10] = '{{5'h01, 8'h00, 5'h01, 3'h5, 1'b1, 1'b1}, {5'h12, 8'h00, 5'h12, 3'h0, 1'b1, 1'b1},
        {5'h12, 8'h00, 5'h11, 3'h0, 1'b1, 1'b0}, {5'h00, 8'h00, 5'h00, 3'h0, 1'b1, 1'b0},
        {5'h05, 8'h83, 5'h05, 3'h3, 1'b1, 1'b1}, {5'h05, 8'h83, 5'h05, 3'h4, 1'b1, 1'b0},
        {5'h05, 8'h03, 5'h05, 3'h4, 1'b1, 1'b1}, {5'h07, 8'h80, 5'h07, 3'h0, 1'b1, 1'b1},
        {5'h07, 8'h87, 5'h07, 3'h7, 1'b0, 1'b0}, {5'h07, 8'h87, 5'h07, 3'h7, 1'b1, 1'b1}};
    assign okay = alarm_match_pkg::RESP_OKAY;
    assign slverr = alarm_match_pkg::RESP_SLVERR;
    always #2.5 clk = ~clk;
    alarm_month_weekday alarm_month_weekday_inst (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .CUR_MONTH(cur_month),
        .CUR_WEEKDAY(cur_weekday), .OTHER_MATCH(other_match), .ALARM_MATCH(alarm_match), .IRQ(irq));
    axil_host_model host_model_inst (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ----
    // Helpers
    // ----
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hung(input logic [1:0] r);
        if (r === 2'h3) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        host_model_inst.write_reg(a, d, r);
        hung(r);
        check({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] d;
        host_model_inst.read_reg(a, d, r);
        hung(r);
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask
    // Polls for the level so that interrupt latency is not assumed.
    task automatic irq_is(input logic e);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (irq === e) break;
        end
        check({31'h0, irq}, {31'h0, e});
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {cur_month, cur_weekday, other_match} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(alarm_match_pkg::OFF_MONTH, 32'h0, okay);
        rd(alarm_match_pkg::OFF_WEEKDAY, 32'h0, okay);
        rd(alarm_match_pkg::OFF_MASK, 32'h0, okay);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(alarm_match_pkg::OFF_MONTH, {27'h0, rows[i].month}, okay);
            wr(alarm_match_pkg::OFF_WEEKDAY, {24'h0, rows[i].wd_reg}, okay);
            @(posedge clk);
            cur_month <= rows[i].cur_month;
            cur_weekday <= rows[i].cur_wd;
            other_match <= rows[i].other;
            repeat (3) @(posedge clk);
            #1;
            check({31'h0, alarm_match}, {31'h0, rows[i].match});
            rd(alarm_match_pkg::OFF_CURRENT, {19'h0, rows[i].cur_month, rows[i].match, 4'h0, rows[i].cur_wd}, okay);
        end
        $display("test match table done");
        wr(alarm_match_pkg::OFF_WEEKDAY, 32'hFFFFFFFF, okay);
        rd(alarm_match_pkg::OFF_WEEKDAY, 32'h87, okay);
        wr(alarm_match_pkg::OFF_WEEKDAY, 32'h87, okay);
        wr(5'h14, 32'h1, slverr);
        rd(5'h14, 32'h0, slverr);
        rd(5'h18, 32'h0, slverr);
        $display("test register access done");
        // The table left a rising alarm and the 00h month code pending, so clear both before unmasking.
        rd(alarm_match_pkg::OFF_STATUS, 32'h3, okay);
        wr(alarm_match_pkg::OFF_MASK, 32'h1, okay);
        other_match <= 1'b0;
        irq_is(1'b0);
        rd(alarm_match_pkg::OFF_STATUS, 32'h0, okay);
        other_match <= 1'b1;
        irq_is(1'b1);
        rd(alarm_match_pkg::OFF_STATUS, 32'h1, okay);
        irq_is(1'b0);
        wr(alarm_match_pkg::OFF_MASK, 32'h0, okay);
        other_match <= 1'b0;
        irq_is(1'b0);
        other_match <= 1'b1;
        irq_is(1'b0);
        rd(alarm_match_pkg::OFF_STATUS, 32'h1, okay);
        wr(alarm_match_pkg::OFF_MASK, 32'h2, okay);
        wr(alarm_match_pkg::OFF_MONTH, 32'h13, okay);
        irq_is(1'b1);
        rd(alarm_match_pkg::OFF_STATUS, 32'h2, okay);
        $display("test interrupt done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(alarm_match_pkg::OFF_MONTH, 32'h0, okay);
        check({31'h0, alarm_match}, 32'h0);
        $display("test second reset done");
        give_verdict();
    end
endmodule

// ===== pkg/alarm_match_pkg.sv
// Shared constants and types for the month and weekday alarm comparator.
package alarm_match_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_MONTH = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_WEEKDAY = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_CURRENT = 5'h10;
    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int MONTH_W = 5;
    localparam int DAY_W = 3;
    localparam int WD_EN_BIT = 7;
    localparam int CUR_MONTH_LSB = 8;
    localparam int EVENT_W = 2;
    localparam int EV_ALARM = 0;
    localparam int EV_BAD_MONTH = 1;
    localparam logic [MONTH_W-1:0] MONTH_INVALID = 5'h00;
    localparam logic [MONTH_W-1:0] MONTH_LAST = 5'h12;
    localparam logic [3:0] BCD_UNITS_MAX = 4'h9;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [MONTH_W-1:0] MONTH_RESET = 5'h00;
    localparam logic [DAY_W-1:0] DAY_RESET = 3'h0;
    localparam logic WD_EN_RESET = 1'b0;
    localparam logic [EVENT_W-1:0] EVENT_RESET = 2'h0;
    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic weekday_alarm_enable;
        logic [DAY_W-1:0] alarm_weekday_value;
    } weekday_alarm_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic lane0;
    } write_hold_type;
endpackage
